//--- kms_defines.svh
// constants of the keyboard matrix scan encoder
`ifndef KMS_DEFINES_SVH
`define KMS_DEFINES_SVH
`define KMS_CLK_NS 50
`define KMS_TICK_NS 20000
`define KMS_TICK_CYC (`KMS_TICK_NS / `KMS_CLK_NS)
`define KMS_BOUNCE_RST 16'h0040
`define KMS_ROWS 9
`define KMS_COLS 10
`define KMS_KEYS 90
`define KMS_GROUPS 4
`define KMS_ENTRIES 360
`define KMS_CODE_W 10
`define KMS_OFS_CTRL 8'h00
`define KMS_OFS_BOUNCE 8'h04
`define KMS_OFS_TADDR 8'h08
`define KMS_OFS_TDATA 8'h0C
`define KMS_OFS_STATUS 8'h10
`define KMS_CTRL_BINARY 0
`define KMS_CTRL_DR_POL 1
`define KMS_CTRL_GATE_DR 2
`define KMS_CTRL_GATE_ANY 3
`define KMS_CTRL_RST 4'h0
`define KMS_ST_ANY 16
`define KMS_ST_HALT 17
`define KMS_ST_DR 18
`define KMS_ST_IDX 24
`define KMS_RESP_OKAY 2'h0
`define KMS_RESP_DECERR 2'h3
`endif

//--- kms_pkg.sv
// types of the keyboard matrix scan encoder
package kms_pkg;
   typedef enum logic [1:0]
   {
      KMS_SCAN = 2'h0,
      KMS_BOUNCE = 2'h1,
      KMS_HOLD = 2'h2
   } kms_state_t;
   typedef logic [9:0] kms_code_t;
   typedef logic [6:0] kms_idx_t;
endpackage

//--- kms_encoder.sv
// keyboard matrix scan encoder with axi4-lite register slave
//
// Overview of operation
// - code table: 360 entries of 10 bits
// - shift/control pick group, rings pick entry
// - nine drive lines, ten sensed lines, 90 keys
// - idle scan steps through every crosspoint
// - key found when selected sense line matches
// - rollover: new key starts bounce delay
// - rollover: confirmed key coded, marked, scan resumes
// - rollover: marked keys ignored, others repeat
// - output buffer holds last accepted code
// - lockout: confirmed key coded, scan halts
// - lockout: scan restarts after key release
// - full scan is 90 scan periods
// - any-key flag high while key held
// - data ready is a pulse
// - any-key flag marks press and release
// - binary variant: 360 distinct 9-bit codes
// - 64 keys: bits two to nine used
// - 90 keys: bits one to nine, mode two-three
// - code latched as one stable character
// - polarity input inverts code, optionally ready
// - gate input gates code, optionally ready/any-key
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "kms_defines.svh"
module kms_encoder
#(
   parameter int TICK_DIV = `KMS_TICK_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output var logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output var logic s_axi_wready,
   output var logic [1:0] s_axi_bresp,
   output var logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output var logic s_axi_arready,
   output var logic [31:0] s_axi_rdata,
   output var logic [1:0] s_axi_rresp,
   output var logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output var logic [8:0] drive_lines,
   input wire logic [9:0] sense_lines,
   input wire logic shift_in,
   input wire logic control_in,
   input wire logic lock_roll_select,
   input wire logic output_polarity_control,
   input wire logic output_gate_enable,
   output var kms_pkg::kms_code_t key_code_bits,
   output var logic data_ready,
   output var logic any_key_flag
);
   import kms_pkg::*;

   typedef struct packed
   {
      kms_state_t state;
      logic [15:0] div;
      logic tick;
      logic [8:0] x_ring;
      logic [9:0] y_ring;
      logic [3:0] x_cnt;
      logic [3:0] y_cnt;
      kms_idx_t idx;
      logic [15:0] bcnt;
      logic [`KMS_KEYS-1:0] enc;
      kms_code_t code;
      logic dr;
      logic [3:0] ctrl;
      logic [15:0] bounce;
      logic [8:0] taddr;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [8:0] drive;
      kms_code_t code_out;
      logic dr_out;
      logic any_out;
   } kms_regs_t;

   kms_regs_t st_r;
   kms_regs_t st_nxt;
   kms_code_t table_mem [`KMS_ENTRIES];
   logic tbl_we;
   logic [8:0] tbl_wa;
   kms_code_t tbl_wd;
   logic match;
   logic lockout;
   logic [8:0] tbl_ra;
   kms_code_t lookup;
   logic accept;
   logic advance;
   logic any_raw;

   // binary variant: mode and key position straight to the pins
   function automatic kms_code_t kms_binary(input logic ctl, input logic sh, input kms_idx_t k);
      kms_code_t b;
      b = 10'h000;
      b[0] = k[6];
      b[1] = ctl;
      b[2] = sh;
      for (int j = 0; j < 6; j++)
      begin
         b[3+j] = k[5-j];
      end
      return b;
   endfunction

   function automatic logic [31:0] kms_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   assign match = |(sense_lines & st_r.y_ring);
   assign lockout = lock_roll_select;
   assign tbl_ra = 9'({control_in, shift_in}) * 9'(`KMS_KEYS) + 9'(st_r.idx);
   assign lookup = st_r.ctrl[`KMS_CTRL_BINARY] ? kms_binary(control_in, shift_in, st_r.idx)
                                                : table_mem[tbl_ra];
   assign accept = st_r.state == KMS_BOUNCE && st_r.tick && st_r.bcnt == 16'h0000 && match;
   assign any_raw = (|st_r.enc) || st_r.state != KMS_SCAN;

   always_comb
   begin
      logic [31:0] wv;
      logic [7:0] wa;
      wv = 32'h0000_0000;
      wa = 8'h00;
      st_nxt = st_r;
      tbl_we = 1'b0;
      tbl_wa = st_r.taddr;
      tbl_wd = st_r.w_data[9:0];
      advance = 1'b0;
      st_nxt.dr = 1'b0;
      // scan-rate enable
      st_nxt.tick = 1'b0;
      if (st_r.div == 16'(TICK_DIV - 1))
      begin
         st_nxt.div = 16'h0000;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.div = st_r.div + 16'h0001;
      end
      case (st_r.state)
         KMS_SCAN:
         begin
            if (st_r.tick)
            begin
               if (match && (lockout || !st_r.enc[st_r.idx]))
               begin
                  st_nxt.state = KMS_BOUNCE;
                  st_nxt.bcnt = st_r.bounce;
               end
               else
               begin
                  if (!match)
                  begin
                     st_nxt.enc[st_r.idx] = 1'b0;
                  end
                  advance = 1'b1;
               end
            end
         end
         KMS_BOUNCE:
         begin
            if (st_r.tick)
            begin
               if (st_r.bcnt != 16'h0000)
               begin
                  st_nxt.bcnt = st_r.bcnt - 16'h0001;
               end
               else if (match)
               begin
                  st_nxt.code = lookup;
                  st_nxt.dr = 1'b1;
                  if (lockout)
                  begin
                     st_nxt.state = KMS_HOLD;
                  end
                  else
                  begin
                     st_nxt.enc[st_r.idx] = 1'b1;
                     st_nxt.state = KMS_SCAN;
                     advance = 1'b1;
                  end
               end
               else
               begin
                  st_nxt.state = KMS_SCAN;
                  advance = 1'b1;
               end
            end
         end
         KMS_HOLD:
         begin
            if (st_r.tick && !match)
            begin
               st_nxt.state = KMS_SCAN;
               advance = 1'b1;
            end
         end
         default:
         begin
            st_nxt.state = KMS_SCAN;
         end
      endcase
      // step the two rings; full scan after 90 steps
      if (advance)
      begin
         st_nxt.y_ring = {st_r.y_ring[8:0], st_r.y_ring[9]};
         if (st_r.y_cnt == 4'(`KMS_COLS - 1))
         begin
            st_nxt.y_cnt = 4'h0;
            st_nxt.x_ring = {st_r.x_ring[7:0], st_r.x_ring[8]};
            st_nxt.x_cnt = (st_r.x_cnt == 4'(`KMS_ROWS - 1)) ? 4'h0 : st_r.x_cnt + 4'h1;
         end
         else
         begin
            st_nxt.y_cnt = st_r.y_cnt + 4'h1;
         end
         st_nxt.idx = (st_r.idx == 7'(`KMS_KEYS - 1)) ? 7'h00 : st_r.idx + 7'h01;
      end
      // output pins, polarity then gate
      st_nxt.drive = st_nxt.x_ring;
      st_nxt.code_out = output_gate_enable ?
                        (st_nxt.code ^ {10{output_polarity_control}}) : 10'h000;
      st_nxt.dr_out = st_nxt.dr ^ (st_r.ctrl[`KMS_CTRL_DR_POL] & output_polarity_control);
      if (st_r.ctrl[`KMS_CTRL_GATE_DR] && !output_gate_enable)
      begin
         st_nxt.dr_out = 1'b0;
      end
      st_nxt.any_out = any_raw && !(st_r.ctrl[`KMS_CTRL_GATE_ANY] && !output_gate_enable);
      // axi write channels
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
         st_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
         st_nxt.wready = 1'b0;
      end
      if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
      begin
         wa = {st_r.aw_addr[7:2], 2'b00};
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `KMS_RESP_OKAY;
         case (wa)
            `KMS_OFS_CTRL:
            begin
               wv = kms_merge({28'h0, st_r.ctrl}, st_r.w_data, st_r.w_strb);
               st_nxt.ctrl = wv[3:0];
            end
            `KMS_OFS_BOUNCE:
            begin
               wv = kms_merge({16'h0, st_r.bounce}, st_r.w_data, st_r.w_strb);
               st_nxt.bounce = wv[15:0];
            end
            `KMS_OFS_TADDR:
            begin
               wv = kms_merge({23'h0, st_r.taddr}, st_r.w_data, st_r.w_strb);
               st_nxt.taddr = wv[8:0];
            end
            `KMS_OFS_TDATA:
            begin
               tbl_we = st_r.taddr < 9'(`KMS_ENTRIES);
               st_nxt.taddr = (st_r.taddr == 9'(`KMS_ENTRIES - 1)) ? 9'h000 : st_r.taddr + 9'h001;
            end
            `KMS_OFS_STATUS:
            begin
               st_nxt.bresp = `KMS_RESP_OKAY;
            end
            default:
            begin
               st_nxt.bresp = `KMS_RESP_DECERR;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
         st_nxt.awready = 1'b1;
         st_nxt.wready = 1'b1;
      end
      // axi read channel
      if (s_axi_arvalid && st_r.arready)
      begin
         st_nxt.arready = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `KMS_RESP_OKAY;
         st_nxt.rdata = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'b00})
            `KMS_OFS_CTRL: st_nxt.rdata[3:0] = st_r.ctrl;
            `KMS_OFS_BOUNCE: st_nxt.rdata[15:0] = st_r.bounce;
            `KMS_OFS_TADDR: st_nxt.rdata[8:0] = st_r.taddr;
            `KMS_OFS_TDATA: st_nxt.rdata[9:0] =
               (st_r.taddr < 9'(`KMS_ENTRIES)) ? table_mem[st_r.taddr] : 10'h000;
            `KMS_OFS_STATUS:
            begin
               st_nxt.rdata[9:0] = st_r.code;
               st_nxt.rdata[`KMS_ST_ANY] = any_raw;
               st_nxt.rdata[`KMS_ST_HALT] = st_r.state == KMS_HOLD;
               st_nxt.rdata[`KMS_ST_DR] = st_r.dr;
               st_nxt.rdata[`KMS_ST_IDX +: 7] = st_r.idx;
            end
            default: st_nxt.rresp = `KMS_RESP_DECERR;
         endcase
      end
      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
         st_nxt.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.state <= KMS_SCAN;
         st_r.x_ring <= 9'h001;
         st_r.y_ring <= 10'h001;
         st_r.drive <= 9'h001;
         st_r.bounce <= `KMS_BOUNCE_RST;
         st_r.ctrl <= `KMS_CTRL_RST;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // code table, loaded by software
   always_ff @(posedge aclk)
   begin
      if (tbl_we)
      begin
         table_mem[tbl_wa] <= tbl_wd;
      end
   end

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign drive_lines = st_r.drive;
   assign key_code_bits = st_r.code_out;
   assign data_ready = st_r.dr_out;
   assign any_key_flag = st_r.any_out;

   default clocking kms_cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_RINGS_ONEHOT: assert property ($onehot(st_r.x_ring) && $onehot(st_r.y_ring))
      else $error("scan rings not one-hot");
   AST_SCAN_STEP: assert property ((st_r.state == KMS_SCAN && st_r.tick && !match)
      |=> st_r.idx != $past(st_r.idx))
      else $error("idle scan did not step");
   AST_BOUNCE_START: assert property ((st_r.state == KMS_SCAN && st_r.tick && match
      && !lockout && !st_r.enc[st_r.idx]) |=> st_r.state == KMS_BOUNCE && st_r.bcnt == st_r.bounce)
      else $error("new key did not start bounce delay");
   AST_ENC_IGNORE: assert property ((st_r.state == KMS_SCAN && st_r.tick && match
      && !lockout && st_r.enc[st_r.idx]) |=> st_r.state == KMS_SCAN && !st_r.dr)
      else $error("encoded key accepted again");
   AST_ROLL_ACCEPT: assert property ((accept && !lockout)
      |=> st_r.dr && st_r.enc[$past(st_r.idx)] && st_r.state == KMS_SCAN)
      else $error("rollover accept incomplete");
   AST_LOCK_HALT: assert property ((accept && lockout) |=> st_r.state == KMS_HOLD ##1
      st_r.idx == $past(st_r.idx, 2))
      else $error("lockout did not halt scan");
   AST_HOLD_STAY: assert property ((st_r.state == KMS_HOLD && match) |=> st_r.state == KMS_HOLD)
      else $error("halt left while key held");
   AST_CODE_KEEP: assert property (!accept |=> $stable(st_r.code))
      else $error("code buffer changed without accept");
   AST_DR_PULSE: assert property (st_r.dr |=> !st_r.dr ##1 !st_r.dr)
      else $error("data ready longer than a pulse");
   AST_WRAP: assert property ((advance && st_r.idx == 7'(`KMS_KEYS - 1)) |=> st_r.idx == 7'h00
      && st_r.x_ring == 9'h001 && st_r.y_ring == 10'h001)
      else $error("scan did not wrap after 90 steps");

   COV_ROLL_ACCEPT: cover property (accept && !lockout);
   COV_LOCK_RELEASE: cover property (st_r.state == KMS_HOLD ##1 st_r.state == KMS_SCAN);
   COV_BOUNCE_FAIL: cover property (st_r.state == KMS_BOUNCE && st_r.tick
      && st_r.bcnt == 16'h0000 && !match);
endmodule
`default_nettype wire

//--- kms_key_matrix.sv
// switch matrix model facing the scan encoder
`timescale 1ns/100ps
`default_nettype none
module kms_key_matrix
(
   input wire logic [8:0] drive_lines,
   input wire logic [89:0] keys_down,
   output logic [9:0] sense_lines
);
   // closed switch joins its driven row to its column, open lines pulled low
   always_comb
   begin
      sense_lines = 10'h000;
      for (int r = 0; r < 9; r++)
         for (int c = 0; c < 10; c++)
            if (drive_lines[r] && keys_down[r * 10 + c])
               sense_lines[c] = 1'b1;
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the keyboard matrix scan encoder
`timescale 1ns/100ps
`default_nettype none
`include "kms_defines.svh"
module tb_top;
   import kms_pkg::*;
   localparam int TDIV = 4;
   localparam int SCAN = 90 * TDIV;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, shift_in, control_in, lock_roll_select, output_polarity_control;
   logic output_gate_enable, data_ready, any_key_flag;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [8:0] drive_lines;
   logic [9:0] sense_lines;
   logic [89:0] keys;
   kms_code_t key_code_bits;
   int num_errors, num_checks, cyc;
   kms_encoder #(.TICK_DIV(TDIV)) dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_lines, .sense_lines, .shift_in,
      .control_in, .lock_roll_select, .output_polarity_control, .output_gate_enable,
      .key_code_bits, .data_ready, .any_key_flag
   );
   kms_key_matrix keyb
   (
      .drive_lines, .keys_down(keys), .sense_lines
   );
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic kms_code_t tv(input int i);
      return 10'((i * 37 + 5) % 1024);
   endfunction
   function automatic kms_code_t bin(input int k, input logic [1:0] g);
      kms_code_t c;
      c = 10'h000;
      c[0] = k[6];
      c[1] = g[1];
      c[2] = g[0];
      for (int j = 0; j < 6; j++)
         c[3 + j] = k[5 - j];
      return c;
   endfunction
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic wait_rdy(input int n, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < n && seen !== 1'b1; i++)
      begin
         @(posedge aclk);
         seen = data_ready;
      end
   endtask
   task automatic press(input int k, input logic [1:0] g, input kms_code_t e);
      logic seen;
      @(posedge aclk);
      {control_in, shift_in} <= g;
      keys[k] <= 1'b1;
      wait_rdy(2 * SCAN, seen);
      chk("ready", 1, seen);
      chk("code", e, key_code_bits);
      chk("anykey on", 1, any_key_flag);
      @(posedge aclk);
      chk("pulse", 0, data_ready);
   endtask
   task automatic drop();
      int n;
      @(posedge aclk);
      keys <= '0;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (any_key_flag !== 1'b0 && n < 2 * SCAN);
      chk("anykey off", 0, any_key_flag);
   endtask
   task automatic row0(output int n, inout logic [8:0] acc);
      n = 0;
      for (int i = 0; i < 2; i++)
         while (drive_lines !== (i == 0 ? 9'h100 : 9'h001))
         begin
            @(posedge aclk);
            n++;
            acc |= drive_lines;
         end
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [8:0] acc;
      int n;
      acc = 9'h000;
      chk("drive", 9'h001, drive_lines);
      chk("code", 10'h000, key_code_bits);
      chk("ready", 0, data_ready);
      chk("anykey", 0, any_key_flag);
      @(posedge aclk);
      aresetn <= 1'b1;
      axr(`KMS_OFS_BOUNCE, d, `KMS_RESP_OKAY);
      chk("bounce", 32'h40, d);
      axr(8'h14, d, `KMS_RESP_DECERR);
      axw(8'h14, 32'h1, `KMS_RESP_DECERR);
      row0(n, acc);
      row0(n, acc);
      chk("scan", SCAN, n);
      chk("rows", 9'h1FF, acc);
      $display("reset and scan test done");
   endtask
   task automatic t_table();
      logic [31:0] d;
      axw(`KMS_OFS_TADDR, 32'h0, `KMS_RESP_OKAY);
      for (int i = 0; i < 360; i++)
         axw(`KMS_OFS_TDATA, 32'(tv(i)), `KMS_RESP_OKAY);
      axr(`KMS_OFS_TADDR, d, `KMS_RESP_OKAY);
      chk("taddr wrap", 32'h0, d);
      axw(`KMS_OFS_TADDR, 32'h167, `KMS_RESP_OKAY);
      axr(`KMS_OFS_TDATA, d, `KMS_RESP_OKAY);
      chk("entry", tv(359), d);
      axw(`KMS_OFS_BOUNCE, 32'h1, `KMS_RESP_OKAY);
      $display("table test done");
   endtask
   task automatic t_roll();
      logic seen;
      press(23, 2'h2, tv(203));
      wait_rdy(2 * SCAN, seen);
      chk("encoded ignored", 0, seen);
      press(57, 2'h2, tv(237));
      drop();
      chk("buffer", tv(237), key_code_bits);
      for (int g = 0; g < 4; g++)
      begin
         press(89, 2'(g), tv(g * 90 + 89));
         drop();
      end
      $display("rollover test done");
   endtask
   task automatic t_out();
      kms_code_t c;
      c = key_code_bits;
      axw(`KMS_OFS_CTRL, 32'h6, `KMS_RESP_OKAY);
      output_polarity_control <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("inverted", kms_code_t'(~c), key_code_bits);
      chk("ready inverted", 1, data_ready);
      output_gate_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("gated", 0, key_code_bits);
      chk("ready gated", 0, data_ready);
      output_polarity_control <= 1'b0;
      output_gate_enable <= 1'b1;
      axw(`KMS_OFS_CTRL, 32'h8, `KMS_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("ungated", c, key_code_bits);
      $display("output control test done");
   endtask
   task automatic t_lock();
      logic seen;
      logic [8:0] d;
      @(posedge aclk);
      lock_roll_select <= 1'b1;
      press(34, 2'h0, tv(34));
      d = drive_lines;
      keys[35] <= 1'b1;
      wait_rdy(SCAN, seen);
      chk("locked out", 0, seen);
      chk("halted", d, drive_lines);
      output_gate_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("anykey gated", 0, any_key_flag);
      output_gate_enable <= 1'b1;
      keys <= '0;
      repeat (15 * TDIV) @(posedge aclk);
      chk("resumed", 1, drive_lines !== d);
      lock_roll_select <= 1'b0;
      drop();
      $display("lockout test done");
   endtask
   task automatic t_bin();
      axw(`KMS_OFS_CTRL, 32'h1, `KMS_RESP_OKAY);
      for (int g = 0; g < 4; g++)
      begin
         press(70, 2'(g), bin(70, 2'(g)));
         drop();
      end
      press(5, 2'h3, bin(5, 2'h3));
      chk("b1 clear", 0, key_code_bits[0]);
      drop();
      $display("binary code test done");
   endtask
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {shift_in, control_in, lock_roll_select, output_polarity_control} = 4'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      keys = '0;
      output_gate_enable = 1'b1;
      aresetn = 1'b0;
      num_errors = 0;
      num_checks = 0;
      cyc = 0;
      repeat (8) @(posedge aclk);
      t_reset();
      t_table();
      t_roll();
      t_out();
      t_lock();
      t_bin();
      tally_and_finish();
   end
endmodule
`default_nettype wire
